// ---- design/canopen_sup_pkg.sv ----
// Package of constants and types for the slave supervision block
package canopen_sup_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam logic [15:0] ADDR_HEARTBEAT = 16'h1017;
   localparam logic [15:0] ADDR_BITRATE = 16'h3142;
   localparam logic [15:0] ADDR_HOLDOFF = 16'h3143;
   localparam logic [15:0] ADDR_EMCY_INT = 16'h3148;
   localparam logic [15:0] ADDR_REPLY_TO = 16'h3149;
   localparam logic [15:0] ADDR_RESTART = 16'h3b05;
   localparam logic [15:0] ADDR_STATUS = 16'h3150;
   localparam logic [15:0] ADDR_SETUP = 16'h3151;
   localparam logic [15:0] RST_HEARTBEAT = 16'h0032;
   localparam logic [15:0] RST_BITRATE = 16'h0000;
   localparam logic [15:0] RST_EMCY_INT = 16'h0004;
   localparam logic [15:0] RST_REPLY_TO = 16'h0000;
   localparam logic [5:0] STEP_MIN = 6'h04;
   localparam logic [5:0] STEP_MAX = 6'h32;
   localparam int CLK_MHZ = 100;
   localparam int TICK_MS = 4;
   localparam int TICK_CYC = TICK_MS * 1000 * CLK_MHZ;
   localparam int RESTART_CYC = 16;
   typedef enum logic [1:0]
   {
      STK_IDLE = 2'b00,
      STK_HOLD = 2'b01,
      STK_RUN = 2'b10
   } stack_state_t;
endpackage

// ---- design/tick_divider.sv ----
// Divider making a one-cycle enable every step of the supervision timers
`timescale 1ns/1ps
module tick_divider #(
   parameter int DIV = 400000
) (
   input wire logic clk,
   input wire logic sys_rst,
   output logic tick
);
   logic [31:0] cnt_r;
   logic [31:0] cnt_nxt;
   logic tick_nxt;

   // Count down and fire one enable pulse at wrap
   always_comb
   begin
      tick_nxt = 1'b0;
      cnt_nxt = cnt_r - 32'h1;
      if (cnt_r == 32'h0)
      begin
         cnt_nxt = 32'(DIV - 1);
         tick_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         cnt_r <= 32'(DIV - 1);
         tick <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         tick <= tick_nxt;
      end
   end
endmodule

// ---- design/step_timer.sv ----
// Period timer counting enable steps up to a programmed limit
`timescale 1ns/1ps
module step_timer (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic tick,
   input wire logic restart,
   input wire logic run,
   input wire logic [5:0] limit,
   output logic expired
);
   logic [5:0] cnt_r;
   logic [5:0] cnt_nxt;
   logic exp_nxt;

   // Restart clears the count; expiry is a single-cycle pulse
   always_comb
   begin
      cnt_nxt = cnt_r;
      exp_nxt = 1'b0;
      if (restart || !run)
         cnt_nxt = 6'h00;
      else if (tick)
      begin
         if (cnt_r + 6'h01 >= limit)
         begin
            exp_nxt = 1'b1;
            cnt_nxt = 6'h00;
         end
         else
            cnt_nxt = cnt_r + 6'h01;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         cnt_r <= 6'h00;
         expired <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         expired <= exp_nxt;
      end
   end
endmodule

// ---- design/canopen_slave_supervision.sv ----
// Supervision and configuration logic of the slave node
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module canopen_slave_supervision
   import canopen_sup_pkg::*;
#(
   parameter int TICK_DIV = TICK_CYC
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [canopen_sup_pkg::ADDR_W-1:0] regAddr,
   input wire logic [canopen_sup_pkg::DATA_W-1:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [canopen_sup_pkg::DATA_W-1:0] regRdata,
   input wire logic pdoTxDone,
   input wire logic pdo1RxIn,
   input wire logic pdo2RxIn,
   input wire logic faultChange,
   output logic heartbeatReq,
   output logic emcyReq,
   output logic [2:0] bitRateIndex,
   output logic stackActive,
   output logic replyTimeoutFault,
   output logic ctrlRestart
);
   logic [15:0] hbPeriod_r;
   logic [15:0] hbPeriod_nxt;
   logic [15:0] bitRate_r;
   logic [15:0] bitRate_nxt;
   logic [15:0] holdoff_r;
   logic [15:0] holdoff_nxt;
   logic [15:0] emcyInt_r;
   logic [15:0] emcyInt_nxt;
   logic [15:0] replyTo_r;
   logic [15:0] replyTo_nxt;
   logic [15:0] rdata_nxt;
   logic [15:0] restartReg_r;
   logic [4:0] restartCnt_r;
   logic [4:0] restartCnt_nxt;
   stack_state_t stk_r;
   stack_state_t stk_nxt;
   logic setupCall;
   logic tick;
   logic p1s1_r, p1s2_r, p2s1_r, p2s2_r, txs1_r, txs2_r, fcs1_r, fcs2_r;
   logic replyArmed_r;
   logic replyArmed_nxt;
   logic fault_r;
   logic fault_nxt;
   logic replyExp;
   logic hbExp;
   logic emcyOpen;
   logic emcyPend_r;
   logic emcyPend_nxt;
   logic emcyGap_r;
   logic emcyGap_nxt;
   logic emcyFire;
   logic faultReported_r;
   logic faultReported_nxt;
   logic rxAny;
   logic restartKick;

   // Clamp a stored step count into the documented 4..50 range
   function automatic logic [5:0] clampStep(input logic [15:0] v);
      if (v < 16'(STEP_MIN))
         return STEP_MIN;
      else if (v > 16'(STEP_MAX))
         return STEP_MAX;
      return v[5:0];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Link inputs arrive from the CAN controller's pins; two-stage synchronisers
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         {p1s1_r, p1s2_r, p2s1_r, p2s2_r} <= 4'h0;
         {txs1_r, txs2_r, fcs1_r, fcs2_r} <= 4'h0;
      end
      else
      begin
         p1s1_r <= pdo1RxIn;
         p1s2_r <= p1s1_r;
         p2s1_r <= pdo2RxIn;
         p2s2_r <= p2s1_r;
         txs1_r <= pdoTxDone;
         txs2_r <= txs1_r;
         fcs1_r <= faultChange;
         fcs2_r <= fcs1_r;
      end
   end

   tick_divider #(.DIV(TICK_DIV)) u_div (
      .clk(clk),
      .sys_rst(sys_rst),
      .tick(tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Register writes; restart and setup are actions, not stored state
   always_comb
   begin
      hbPeriod_nxt = hbPeriod_r;
      bitRate_nxt = bitRate_r;
      holdoff_nxt = holdoff_r;
      emcyInt_nxt = emcyInt_r;
      replyTo_nxt = replyTo_r;
      setupCall = 1'b0;
      restartKick = 1'b0;
      if (regWr)
      begin
         unique case (regAddr)
            ADDR_HEARTBEAT: hbPeriod_nxt = {10'h0, clampStep(regWdata)};
            ADDR_BITRATE: bitRate_nxt = regWdata;
            ADDR_HOLDOFF: holdoff_nxt = {15'h0000, regWdata[0]};
            ADDR_EMCY_INT: emcyInt_nxt = {10'h0, clampStep(regWdata)};
            ADDR_REPLY_TO: replyTo_nxt = (regWdata > 16'(STEP_MAX)) ? 16'(STEP_MAX) : regWdata;
            ADDR_RESTART: restartKick = (regWdata == 16'h0001);
            ADDR_SETUP: setupCall = 1'b1;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         hbPeriod_r <= RST_HEARTBEAT;
         bitRate_r <= RST_BITRATE;
         emcyInt_r <= RST_EMCY_INT;
         replyTo_r <= RST_REPLY_TO;
      end
      else
      begin
         hbPeriod_r <= hbPeriod_nxt;
         bitRate_r <= bitRate_nxt;
         emcyInt_r <= emcyInt_nxt;
         replyTo_r <= replyTo_nxt;
      end
   end

   // Holdoff survives a soft restart, so that it can act at the next start-up
   always_ff @(posedge clk)
   begin
      if (sys_rst && !ctrlRestart)
         holdoff_r <= 16'h0000;
      else
         holdoff_r <= holdoff_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Restart pulse counter; the wrapper feeds ctrlRestart back to sys_rst, which clears the count after one cycle.
   // Register contents other than holdoff survive only if the system keeps them in nonvolatile store.
   always_comb
   begin
      restartCnt_nxt = restartCnt_r;
      if (restartKick)
         restartCnt_nxt = 5'(RESTART_CYC);
      else if (restartCnt_r != 5'h00)
         restartCnt_nxt = restartCnt_r - 5'h01;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         restartCnt_r <= 5'h00;
      else
         restartCnt_r <= restartCnt_nxt;
   end

   assign ctrlRestart = (restartCnt_r != 5'h00);
   assign restartReg_r = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // Stack start-up: holdoff is sampled one cycle after reset release
   always_comb
   begin
      stk_nxt = stk_r;
      unique case (stk_r)
         STK_IDLE: stk_nxt = holdoff_r[0] ? STK_HOLD : STK_RUN;
         STK_HOLD:
            if (setupCall && !holdoff_r[0])
               stk_nxt = STK_RUN;
         STK_RUN: stk_nxt = STK_RUN;
         default: stk_nxt = STK_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         stk_r <= STK_IDLE;
      else
         stk_r <= stk_nxt;
   end

   assign stackActive = (stk_r == STK_RUN);

   ////////////////////////////////////////////////////////////////////////////
   // Heartbeat every clamped step count of 4 ms
   step_timer u_hb (
      .clk(clk),
      .sys_rst(sys_rst),
      .tick(tick),
      .restart(1'b0),
      .run(stackActive),
      .limit(clampStep(hbPeriod_r)),
      .expired(hbExp)
   );
   assign heartbeatReq = hbExp;

   ////////////////////////////////////////////////////////////////////////////
   // Reply watchdog armed by an outgoing PDO, cleared and disarmed by either incoming PDO
   assign rxAny = p1s2_r | p2s2_r;

   step_timer u_reply (
      .clk(clk),
      .sys_rst(sys_rst),
      .tick(tick),
      .restart(rxAny | txs2_r),
      .run(replyArmed_r && replyTo_r != 16'h0000),
      .limit(replyTo_r[5:0]),
      .expired(replyExp)
   );

   always_comb
   begin
      replyArmed_nxt = replyArmed_r;
      if (txs2_r)
         replyArmed_nxt = stackActive;
      else if (rxAny)
         replyArmed_nxt = 1'b0;
      fault_nxt = fault_r | (replyExp && replyTo_r != 16'h0000);
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         replyArmed_r <= 1'b0;
         fault_r <= 1'b0;
      end
      else
      begin
         replyArmed_r <= replyArmed_nxt;
         fault_r <= fault_nxt;
      end
   end

   assign replyTimeoutFault = fault_r;

   ////////////////////////////////////////////////////////////////////////////
   // Emergency spacing: one message, then a closed gap of the programmed time
   step_timer u_emcy (
      .clk(clk),
      .sys_rst(sys_rst),
      .tick(tick),
      .restart(emcyFire),
      .run(emcyGap_r),
      .limit(clampStep(emcyInt_r)),
      .expired(emcyOpen)
   );

   assign emcyFire = emcyPend_r && !emcyGap_r && stackActive;

   always_comb
   begin
      faultReported_nxt = faultReported_r | fault_r;
      emcyPend_nxt = emcyPend_r;
      if (fcs2_r || (fault_r && !faultReported_r))
         emcyPend_nxt = 1'b1;
      else if (emcyFire)
         emcyPend_nxt = 1'b0;
      emcyGap_nxt = emcyGap_r;
      if (emcyFire)
         emcyGap_nxt = 1'b1;
      else if (emcyOpen)
         emcyGap_nxt = 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         emcyPend_r <= 1'b0;
         emcyGap_r <= 1'b0;
         faultReported_r <= 1'b0;
      end
      else
      begin
         emcyPend_r <= emcyPend_nxt;
         emcyGap_r <= emcyGap_nxt;
         faultReported_r <= faultReported_nxt;
      end
   end

   assign emcyReq = emcyFire;

   ////////////////////////////////////////////////////////////////////////////
   // Bit rate index 0..7 from signed code; out-of-range codes fall back to 125k
   always_comb
   begin
      if ($signed(bitRate_r) >= -16'sd3 && $signed(bitRate_r) <= 16'sd4)
         bitRateIndex = 3'(bitRate_r + 16'h0003);
      else
         bitRateIndex = 3'h3;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path, data one cycle after the strobe
   always_comb
   begin
      rdata_nxt = 16'h0000;
      if (regRd)
      begin
         unique case (regAddr)
            ADDR_HEARTBEAT: rdata_nxt = hbPeriod_r;
            ADDR_BITRATE: rdata_nxt = bitRate_r;
            ADDR_HOLDOFF: rdata_nxt = holdoff_r;
            ADDR_EMCY_INT: rdata_nxt = emcyInt_r;
            ADDR_REPLY_TO: rdata_nxt = replyTo_r;
            ADDR_RESTART: rdata_nxt = restartReg_r;
            ADDR_STATUS: rdata_nxt = {12'h000, emcyGap_r, replyArmed_r, fault_r, stackActive};
            default: rdata_nxt = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         regRdata <= 16'h0000;
      else
         regRdata <= rdata_nxt;
   end
endmodule

// ---- tb/canopen_sup_monitor.sv ----
// Port checker for the slave supervision block
`timescale 1ns/1ps
module canopen_sup_monitor
   import canopen_sup_pkg::*;
#(
   parameter int TICK_DIV = 10
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [canopen_sup_pkg::ADDR_W-1:0] regAddr,
   input wire logic [canopen_sup_pkg::DATA_W-1:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [canopen_sup_pkg::DATA_W-1:0] regRdata,
   input wire logic pdoTxDone,
   input wire logic pdo1RxIn,
   input wire logic pdo2RxIn,
   input wire logic faultChange,
   input wire logic heartbeatReq,
   input wire logic emcyReq,
   input wire logic [2:0] bitRateIndex,
   input wire logic stackActive,
   input wire logic replyTimeoutFault,
   input wire logic ctrlRestart
);
   logic [15:0] emGap_r, emGap_nxt, hbGap_r, hbGap_nxt;
   logic pend_r, pend_nxt, off_r, off_nxt;
   logic hold_r, hold_nxt;
   ////////////////////////////////////////////////////////////////////////////////
   // Gaps saturate so a long idle never wraps round to a short gap
   always_comb
   begin
      emGap_nxt = sys_rst ? 16'hffff : emcyReq ? 16'h0 : emGap_r + {15'h0, emGap_r != 16'hffff};
      hbGap_nxt = sys_rst ? 16'hffff : heartbeatReq ? 16'h0 : hbGap_r + {15'h0, hbGap_r != 16'hffff};
      pend_nxt = !sys_rst && (pdoTxDone || (pend_r && !pdo1RxIn && !pdo2RxIn));
      off_nxt = sys_rst || ((regWr && regAddr == ADDR_REPLY_TO) ? regWdata == 16'h0 : off_r);
      // Holdoff setting as written; only a reset without restart clears it
      hold_nxt = (sys_rst && !ctrlRestart) ? 1'b0 :
         (regWr && regAddr == ADDR_HOLDOFF) ? regWdata[0] : hold_r;
   end
   // Helper state registers
   always_ff @(posedge clk)
   begin
      emGap_r <= emGap_nxt;
      hbGap_r <= hbGap_nxt;
      pend_r <= pend_nxt;
      off_r <= off_nxt;
      hold_r <= hold_nxt;
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   AST_RATE_MAP: assert property (regWr && regAddr == ADDR_BITRATE && ($signed(regWdata) inside {[-3:4]})
      |=> {13'h0, bitRateIndex} == (($past(regWdata) + 16'h3) & 16'h7)) else $error("bit rate index wrong");
   AST_HB_SPACING: assert property (heartbeatReq |-> hbGap_r >= 16'(3 * TICK_DIV))
      else $error("heartbeat too soon");
   AST_EMCY_SPACING: assert property (emcyReq |-> emGap_r >= 16'(3 * TICK_DIV))
      else $error("emergency too soon");
   AST_FAULT_CAUSE: assert property ($rose(replyTimeoutFault) |-> pend_r)
      else $error("fault without unanswered PDO");
   AST_FAULT_OFF: assert property (off_r |-> !$rose(replyTimeoutFault))
      else $error("fault while check disabled");
   AST_FAULT_LATCH: assert property (replyTimeoutFault |=> replyTimeoutFault)
      else $error("fault not held");
   AST_RESTART: assert property (regWr && regAddr == ADDR_RESTART && regWdata == 16'h1
      |-> ##[1:20] ctrlRestart) else $error("restart missing");
   AST_STACK_UP: assert property ($fell(sys_rst) && !hold_r |-> ##[1:3] stackActive)
      else $error("stack not started");
   AST_STACK_HOLD: assert property ($fell(sys_rst) && hold_r |-> ##2 !stackActive)
      else $error("stack started despite holdoff");
   AST_RDATA_IDLE: assert property (!regRd |=> regRdata == 16'h0)
      else $error("read data outside slot");
   COV_HB: cover property (heartbeatReq);
   COV_EMCY: cover property (emcyReq);
   COV_FAULT: cover property ($rose(replyTimeoutFault));
   COV_HOLD: cover property ($fell(sys_rst) && hold_r);
endmodule

// ---- tb/canopen_master_model.sv ----
// Behavioural CAN master answering outgoing PDOs
`timescale 1ns/1ps
module canopen_master_model (
   input wire logic clk,
   input wire logic [1:0] mode,
   input wire logic pdoTxDone,
   output logic pdo1RxIn,
   output logic pdo2RxIn
);
   logic [4:0] dly_r = 5'h00;
   logic ans1_r = 1'b0;
   logic ans2_r = 1'b0;
   // Mode 1 answers soon on the first PDO, mode 2 late on the second, 0 stays silent
   always @(posedge clk)
   begin
      dly_r <= (pdoTxDone && mode != 2'h0) ? ((mode == 2'h1) ? 5'h03 : 5'h14) : dly_r - {4'h0, dly_r != 5'h0};
      ans1_r <= dly_r == 5'h01 && mode == 2'h1;
      ans2_r <= dly_r == 5'h01 && mode == 2'h2;
   end
   assign pdo1RxIn = ans1_r;
   assign pdo2RxIn = ans2_r;
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the slave supervision block
`timescale 1ns/1ps
module testbench;
   import canopen_sup_pkg::*;
   localparam int TD = 10;
   localparam logic [15:0] AD [7] = '{ADDR_HEARTBEAT, ADDR_BITRATE, ADDR_EMCY_INT, ADDR_REPLY_TO, ADDR_HOLDOFF, ADDR_RESTART, 16'h0};
   localparam logic [15:0] EX [7] = '{RST_HEARTBEAT, RST_BITRATE, RST_EMCY_INT, RST_REPLY_TO, 16'h0, 16'h0, 16'h0};
   logic clk, rstBench, regWr, regRd, pdoTxDone, faultChange, pdo1RxIn, pdo2RxIn;
   logic heartbeatReq, emcyReq, stackActive, replyTimeoutFault, ctrlRestart;
   logic [15:0] regAddr, regWdata, regRdata, rdv;
   logic [2:0] bitRateIndex;
   logic [1:0] mode;
   int n_errors = 0;
   int n_tests = 0;
   int t;
   // Restart loops back into reset as the system does
   wire logic sys_rst = rstBench | ctrlRestart;
   wire logic [3:0] obs = {ctrlRestart, replyTimeoutFault, emcyReq, heartbeatReq};
   canopen_slave_supervision #(.TICK_DIV(TD)) canopen_slave_supervision_inst (
      .clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .pdoTxDone(pdoTxDone), .pdo1RxIn(pdo1RxIn),
      .pdo2RxIn(pdo2RxIn), .faultChange(faultChange), .heartbeatReq(heartbeatReq),
      .emcyReq(emcyReq), .bitRateIndex(bitRateIndex), .stackActive(stackActive),
      .replyTimeoutFault(replyTimeoutFault), .ctrlRestart(ctrlRestart));
   canopen_master_model canopen_master_model_inst (.clk(clk), .mode(mode),
      .pdoTxDone(pdoTxDone), .pdo1RxIn(pdo1RxIn), .pdo2RxIn(pdo2RxIn));
   // Clock
   always #5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e)
      begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         n_errors++;
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [15:0] a);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
      rdv = regRdata;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Bounded wait; t holds the cycles spent
   task automatic waitOn(input int w, input int lim);
      t = 0;
      #1;
      while (obs[w] !== 1'b1 && t < lim)
      begin
         cyc(1);
         t++;
      end
   endtask
   task automatic txPdo(input logic [1:0] m);
      @(posedge clk);
      mode <= m;
      pdoTxDone <= 1'b1;
      @(posedge clk);
      pdoTxDone <= 1'b0;
   endtask
   task automatic stop_test;
      if (n_errors == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Reset values, an unmapped write and the reply period clamp
   task automatic testRegs;
      chk("bitRateIndex", 16'h3, {13'h0, bitRateIndex});
      wr(16'h0, 16'h1234);
      for (int i = 0; i < 7; i++)
      begin
         rd(AD[i]);
         chk("regRdata", EX[i], rdv);
      end
      wr(ADDR_REPLY_TO, 16'h0064);
      rd(ADDR_REPLY_TO);
      chk("replyPeriod", 16'h0032, rdv);
      wr(ADDR_REPLY_TO, 16'h0);
   endtask
   // Every in-range bit-rate code, -3 to 4, in turn
   task automatic testRate;
      for (int i = 0; i < 8; i++)
      begin
         wr(ADDR_BITRATE, 16'(i - 3));
         cyc(1);
         chk("bitRateIndex", 16'(i), {13'h0, bitRateIndex});
      end
   endtask
   // Shortest heartbeat period after a clamped write
   task automatic testHeartbeat;
      wr(ADDR_HEARTBEAT, 16'h3);
      rd(ADDR_HEARTBEAT);
      chk("heartbeatPeriod", 16'h4, rdv);
      waitOn(0, 60 * TD);
      cyc(1);
      waitOn(0, 60 * TD);
      chk("heartbeatSpacing", 16'h1, 16'(t >= 3 * TD && t < 5 * TD));
   endtask
   // Fault state flapping every few cycles must not flood the bus
   task automatic testEmcy;
      int last;
      int cnt;
      last = -1000;
      cnt = 0;
      for (int i = 0; i < 40 * TD; i++)
      begin
         @(posedge clk);
         faultChange <= i[2];
         #1;
         if (emcyReq === 1'b1)
         begin
            chk("emcyGap", 16'h1, 16'(i - last >= 3 * TD));
            last = i;
            cnt++;
         end
      end
      chk("emcyCount", 16'h1, 16'(cnt > 2 && cnt < 15));
      @(posedge clk);
      faultChange <= 1'b0;
   endtask
   // Disabled check, both answers, then a silent master
   task automatic testReply;
      txPdo(2'h0);
      cyc(60 * TD);
      chk("faultDisabled", 16'h0, 16'(replyTimeoutFault));
      txPdo(2'h1);
      cyc(10);
      wr(ADDR_REPLY_TO, 16'h5);
      for (int m = 1; m < 3; m++)
      begin
         txPdo(2'(m));
         cyc(8 * TD);
         chk("faultAnswered", 16'h0, 16'(replyTimeoutFault));
      end
      txPdo(2'h0);
      waitOn(2, 10 * TD);
      chk("faultTime", 16'h1, 16'(t >= 3 * TD && t <= 5 * TD + 5));
      waitOn(1, 6 * TD);
      chk("faultEmcy", 16'h1, 16'(emcyReq));
      cyc(10 * TD);
      rd(ADDR_STATUS);
      chk("faultHeld", 16'h1, 16'(rdv[1]));
   endtask
   // Soft restart clears everything but holdoff; holdoff and setup afterwards
   task automatic testRestart;
      wr(ADDR_RESTART, 16'h1);
      waitOn(3, 20);
      chk("ctrlRestart", 16'h1, 16'(ctrlRestart));
      cyc(30);
      chk("faultCleared", 16'h0, 16'(replyTimeoutFault));
      chk("stackActive", 16'h1, 16'(stackActive));
      rd(ADDR_REPLY_TO);
      chk("replyReset", RST_REPLY_TO, rdv);
      wr(ADDR_HOLDOFF, 16'h1); // Settings go back only into this same block
      rd(ADDR_HOLDOFF);
      chk("holdoff", 16'h1, rdv);
      wr(ADDR_RESTART, 16'h1);
      cyc(30);
      chk("stackHeld", 16'h0, 16'(stackActive));
      rd(ADDR_HOLDOFF);
      chk("holdoffKept", 16'h1, rdv);
      wr(ADDR_SETUP, 16'h1);
      cyc(2);
      chk("setupRefused", 16'h0, 16'(stackActive));
      wr(ADDR_HOLDOFF, 16'h0);
      cyc(2);
      chk("stackWaits", 16'h0, 16'(stackActive));
      wr(ADDR_SETUP, 16'h1);
      cyc(2);
      chk("stackSetup", 16'h1, 16'(stackActive));
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      clk = 1'b0;
      rstBench = 1'b1;
      {regWr, regRd, pdoTxDone, faultChange} = 4'h0;
      {regAddr, regWdata} = 32'h0;
      mode = 2'h0;
      repeat (5) @(posedge clk);
      rstBench <= 1'b0;
      cyc(3);
      testRegs;
      testRate;
      testHeartbeat;
      testEmcy;
      testReply;
      testRestart;
      stop_test;
   end
   // Watchdog at 20000 cycles, well beyond the under two thousand cycles the tests need
   initial
   begin
      #200000;
      n_errors++;
      stop_test;
   end
endmodule
bind canopen_slave_supervision canopen_sup_monitor #(.TICK_DIV(TICK_DIV)) canopen_sup_monitor_inst (
   .clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
   .regRd(regRd), .regRdata(regRdata), .pdoTxDone(pdoTxDone), .pdo1RxIn(pdo1RxIn),
   .pdo2RxIn(pdo2RxIn), .faultChange(faultChange), .heartbeatReq(heartbeatReq),
   .emcyReq(emcyReq), .bitRateIndex(bitRateIndex), .stackActive(stackActive),
   .replyTimeoutFault(replyTimeoutFault), .ctrlRestart(ctrlRestart));
